// >>> hw/dps_pkg.sv
// constants and types shared by both ends of the device power-state link
// assumes one clock domain at 100 MHz and an active-low async reset
package dps_pkg;

    // ------------------------------------------------------------------
    // power states, two-bit status code
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DPS_ON    = 2'h0,
        DPS_LIGHT = 2'h1,
        DPS_DEEP  = 2'h2,
        DPS_OFF   = 2'h3
    } dps_pwr_e;

    // ------------------------------------------------------------------
    // request codes on the command channel
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DPS_REQ_SET_STATE  = 2'h0,
        DPS_REQ_GET_STATUS = 2'h1,
        DPS_REQ_SET_WAKE   = 2'h2,
        DPS_REQ_CLR_WAKE   = 2'h3
    } dps_req_e;

    // ------------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------------
    localparam int STAT_W        = 8;
    localparam int STAT_STATE_LO = 0;
    localparam int STAT_WAKE_EN  = 2;
    localparam int STAT_BUSY     = 3;
    localparam int STAT_AUDIO    = 4;
    localparam int STAT_LIGHT_OK = 5;

    // ------------------------------------------------------------------
    // capability descriptor
    // ------------------------------------------------------------------
    localparam int DESC_W = 32;
    localparam logic [7:0]  DESC_POWER_MA   = 8'h64;
    localparam logic [15:0] DESC_OFF_UP_MS  = 16'h01F4;
    localparam logic [7:0]  DESC_FLAGS_BASE = 8'h00;
    localparam int DESC_FLAG_WAKE    = 0;
    localparam int DESC_FLAG_BATTERY = 1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int LOWPWR_MAX_MS  = 100;
    localparam int TRANS_CYC      = 16;
    localparam int OFF_UP_CYC     = 64;
    localparam int CNT_W          = 16;
    localparam int LOWPWR_MAX_CYC = LOWPWR_MAX_MS * 1000 * CLK_MHZ;
    localparam int RESUME_CYC     = 8;

endpackage

// >>> hw/dps_link_if.sv
// command and status channel between power-policy host and device
// assumes both ends share clk; wake is a fixed-length pulse driven by the device
`timescale 1ns/100ps
interface dps_link_if;
    logic                         req_vld;
    dps_pkg::dps_req_e            req_code;
    dps_pkg::dps_pwr_e            req_state;
    logic                         rsp_vld;
    logic [dps_pkg::STAT_W-1:0]   rsp_stat;
    logic [dps_pkg::DESC_W-1:0]   desc;
    logic                         resume;

    modport dev
    (
        input  req_vld, req_code, req_state,
        output rsp_vld, rsp_stat, desc, resume
    );
    modport host
    (
        output req_vld, req_code, req_state,
        input  rsp_vld, rsp_stat, desc, resume
    );
endinterface

// >>> hw/dps_dev.sv
// device end: power-state machine, wake logic, capability descriptor
// assumes host keeps one request outstanding until rsp_vld
`timescale 1ns/100ps
module dps_dev
#(
    parameter bit IS_AUDIO  = 1'b1,
    parameter bit HAS_LIGHT = 1'b1,
    parameter bit HAS_WAKE  = 1'b1,
    parameter bit HAS_BATT  = 1'b0
)
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    dps_link_if.dev         link,
    input  wire logic       wake_evt,
    output logic            func_en,
    output logic            ctx_keep,
    output logic            init_pls,
    output logic            ctx_lost
);
    // ------------------------------------------------------------------
    // state and next values
    // ------------------------------------------------------------------
    dps_pkg::dps_pwr_e                cur_r, tgt_r;
    logic [dps_pkg::CNT_W-1:0]        cnt_r;
    logic                             busy_r, wake_en_r, rsp_vld_r, resume_r, init_r, lost_r;
    logic [dps_pkg::STAT_W-1:0]       stat_r;
    logic [dps_pkg::CNT_W-1:0]        rs_cnt_r;

    // ------------------------------------------------------------------
    // request decoding
    // ------------------------------------------------------------------
    wire logic set_req  = ce && link.req_vld && !rsp_vld_r
                          && link.req_code == dps_pkg::DPS_REQ_SET_STATE;
    wire logic any_req  = ce && link.req_vld && !rsp_vld_r;
    // only states the class allows are accepted; others keep state
    wire logic st_ok    = (link.req_state == dps_pkg::DPS_ON)
                       || (link.req_state == dps_pkg::DPS_OFF)
                       || (IS_AUDIO && link.req_state == dps_pkg::DPS_DEEP)
                       || (IS_AUDIO && HAS_LIGHT && link.req_state == dps_pkg::DPS_LIGHT);
    wire logic start    = set_req && !busy_r && st_ok && link.req_state != cur_r;
    // leaving off takes OFF_UP_CYC cycles, not the advertised DESC_OFF_UP_MS; others TRANS_CYC
    wire logic [dps_pkg::CNT_W-1:0] dur =
        (cur_r == dps_pkg::DPS_OFF) ? dps_pkg::CNT_W'(dps_pkg::OFF_UP_CYC)
                                    : dps_pkg::CNT_W'(dps_pkg::TRANS_CYC);
    wire logic done     = busy_r && cnt_r == '0;
    wire logic wake_ok  = HAS_WAKE && wake_en_r && cur_r != dps_pkg::DPS_ON
                          && !busy_r;
    wire logic [dps_pkg::STAT_W-1:0] stat_nxt =
    {
        2'b00,
        HAS_LIGHT && IS_AUDIO,
        IS_AUDIO,
        busy_r,
        wake_en_r,
        cur_r
    };

    // ------------------------------------------------------------------
    // power-state sequencing; reset is the power-return initialiser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur_r  <= dps_pkg::DPS_ON;
            tgt_r  <= dps_pkg::DPS_ON;
            busy_r <= 1'b0;
            cnt_r  <= '0;
            init_r <= 1'b1;
            lost_r <= 1'b0;
        end
        else if (ce)
        begin
            init_r <= 1'b0;
            if (start)
            begin
                tgt_r  <= link.req_state;
                busy_r <= 1'b1;
                cnt_r  <= dur;
            end
            else if (busy_r)
                cnt_r <= cnt_r - 1'b1;
            if (done)
            begin
                busy_r <= 1'b0;
                cur_r  <= tgt_r;
                // context drops only in deep and off; light keeps it all
                lost_r <= (tgt_r == dps_pkg::DPS_OFF) || (tgt_r == dps_pkg::DPS_DEEP);
                init_r <= (cur_r == dps_pkg::DPS_OFF) && (tgt_r == dps_pkg::DPS_ON);
            end
        end
    end

    // ------------------------------------------------------------------
    // answers, wake enable and resume signalling
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_vld_r <= 1'b0;
            stat_r    <= '0;
            wake_en_r <= 1'b0;
            resume_r  <= 1'b0;
            rs_cnt_r  <= '0;
        end
        else if (ce)
        begin
            rsp_vld_r <= any_req;
            if (any_req)
                stat_r <= stat_nxt;
            if (any_req && link.req_code == dps_pkg::DPS_REQ_SET_WAKE)
                wake_en_r <= HAS_WAKE;
            else if (any_req && link.req_code == dps_pkg::DPS_REQ_CLR_WAKE)
                wake_en_r <= 1'b0;
            if (wake_evt && wake_ok && rs_cnt_r == '0)
            begin
                resume_r <= 1'b1;
                rs_cnt_r <= dps_pkg::CNT_W'(dps_pkg::RESUME_CYC);
            end
            else if (rs_cnt_r != '0)
                rs_cnt_r <= rs_cnt_r - 1'b1;
            else
                resume_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // outputs; descriptor is constant so it is a plain assignment
    // ------------------------------------------------------------------
    assign link.rsp_vld  = rsp_vld_r;
    assign link.rsp_stat = stat_r;
    assign link.resume   = resume_r;
    assign link.desc     =
    {
        dps_pkg::DESC_OFF_UP_MS,
        dps_pkg::DESC_POWER_MA,
        dps_pkg::DESC_FLAGS_BASE | 8'(HAS_WAKE) | (8'(HAS_BATT) << dps_pkg::DESC_FLAG_BATTERY)
    };
    assign func_en  = (cur_r == dps_pkg::DPS_ON) && !busy_r;
    assign ctx_keep = (cur_r == dps_pkg::DPS_LIGHT);
    assign init_pls = init_r;
    assign ctx_lost = lost_r;
endmodule

// >>> hw/dps_host.sv
// host end: issues state, status and wake requests; saves context
// assumes dps_dev answers every request one cycle after taking it
`timescale 1ns/100ps
module dps_host
(
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         ce,
    dps_link_if.host                          link,
    input  wire logic                         cmd_vld,
    input  wire dps_pkg::dps_req_e            cmd_code,
    input  wire dps_pkg::dps_pwr_e            cmd_state,
    output logic                              cmd_rdy,
    output logic                              done,
    output logic [dps_pkg::STAT_W-1:0]        status,
    output logic                              save_ctx,
    output logic                              restore_ctx,
    output logic                              wake_seen
);
    logic                         req_vld_r, done_r, save_r, rest_r, wake_r, deep_r;
    dps_pkg::dps_req_e            code_r;
    dps_pkg::dps_pwr_e            st_r;
    logic [dps_pkg::STAT_W-1:0]   stat_r;

    // ------------------------------------------------------------------
    // request launch and decode
    // ------------------------------------------------------------------
    wire logic take     = ce && cmd_vld && !req_vld_r;
    wire logic to_deep  = cmd_code == dps_pkg::DPS_REQ_SET_STATE
                          && cmd_state == dps_pkg::DPS_DEEP;
    wire logic back_on  = cmd_code == dps_pkg::DPS_REQ_SET_STATE
                          && cmd_state == dps_pkg::DPS_ON && deep_r;

    // ------------------------------------------------------------------
    // one request outstanding; context saved before deep entry
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_vld_r <= 1'b0;
            code_r    <= dps_pkg::DPS_REQ_GET_STATUS;
            st_r      <= dps_pkg::DPS_ON;
            done_r    <= 1'b0;
            stat_r    <= '0;
            save_r    <= 1'b0;
            rest_r    <= 1'b0;
            deep_r    <= 1'b0;
            wake_r    <= 1'b0;
        end
        else if (ce)
        begin
            done_r <= 1'b0;
            save_r <= take && to_deep;
            rest_r <= take && back_on;
            wake_r <= link.resume;
            if (take)
            begin
                req_vld_r <= 1'b1;
                code_r    <= cmd_code;
                st_r      <= cmd_state;
                if (to_deep)
                    deep_r <= 1'b1;
                else if (back_on)
                    deep_r <= 1'b0;
            end
            else if (link.rsp_vld)
            begin
                req_vld_r <= 1'b0;
                done_r    <= 1'b1;
                stat_r    <= link.rsp_stat;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.req_vld   = req_vld_r;
    assign link.req_code  = code_r;
    assign link.req_state = st_r;
    assign cmd_rdy        = !req_vld_r;
    assign done           = done_r;
    assign status         = stat_r;
    assign save_ctx       = save_r;
    assign restore_ctx    = rest_r;
    assign wake_seen      = wake_r;
endmodule

// >>> verification/dps_link_properties.sv
// checker for the power-state link between host end and device end
// assumes ce tied high and the audio build with light state and wake
`timescale 1ns/100ps
module dps_link_properties
(
    input wire logic                       clk,
    input wire logic                       rst_b,
    input wire logic                       req_vld,
    input wire dps_pkg::dps_req_e          req_code,
    input wire dps_pkg::dps_pwr_e          req_state,
    input wire logic                       rsp_vld,
    input wire logic [dps_pkg::STAT_W-1:0] rsp_stat,
    input wire logic [dps_pkg::DESC_W-1:0] desc,
    input wire logic                       resume
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ----
    // wake enable as last commanded
    // ----
    logic taken;
    logic wake_on_r;
    assign taken = req_vld && !rsp_vld;

    // tracked here so resume is gated without trusting rsp_stat
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wake_on_r <= 1'b0;
        else if (taken && req_code == dps_pkg::DPS_REQ_SET_WAKE)
            wake_on_r <= 1'b1;
        else if (taken && req_code == dps_pkg::DPS_REQ_CLR_WAKE)
            wake_on_r <= 1'b0;
    end

    // ----
    // link properties
    // ----
    property p_answer; taken |=> rsp_vld; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse; rsp_vld |=> !rsp_vld && !req_vld; endproperty
    a_pulse: assert property (p_pulse) else $error("bad pulse");
    property p_hold; taken |=> $stable(req_code) && $stable(req_state); endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_class; rsp_vld |-> rsp_stat[4] && rsp_stat[5]; endproperty
    a_class: assert property (p_class) else $error("class bits");
    property p_stat; !rsp_vld |-> $stable(rsp_stat); endproperty
    a_stat: assert property (p_stat) else $error("status moved");
    property p_desc; desc == {16'h01F4, 8'h64, 8'h01}; endproperty
    a_desc: assert property (p_desc) else $error("descriptor");
    property p_res_len; $rose(resume) |-> resume[*8] ##1 resume ##1 !resume; endproperty
    a_res_len: assert property (p_res_len) else $error("resume length");
    property p_res_gate; $rose(resume) |-> wake_on_r; endproperty
    a_res_gate: assert property (p_res_gate) else $error("wake off");
endmodule

// >>> verification/device_power_state_ctrl_tb.sv
// bench joining host end and device end over the link interface
// assumes the default audio build of the device end
`timescale 1ns/100ps
module device_power_state_ctrl_tb;
    logic              clk, rst_b, ce, cmd_vld, wake_evt, wake_q;
    logic              cmd_rdy, done, save_ctx, restore_ctx, wake_seen;
    logic              func_en, ctx_keep, init_pls, ctx_lost;
    logic [7:0]        status;
    dps_pkg::dps_req_e cmd_code;
    dps_pkg::dps_pwr_e cmd_state;
    int                failures, n_tests, cyc, n_save, n_rest, n_init, n_wake, k;

    dps_link_if link_i ();
    dps_dev u_dps_dev (.clk(clk), .rst_b(rst_b), .ce(ce), .link(link_i), .wake_evt(wake_evt),
        .func_en(func_en), .ctx_keep(ctx_keep), .init_pls(init_pls), .ctx_lost(ctx_lost));
    dps_host u_dps_host (.clk(clk), .rst_b(rst_b), .ce(ce), .link(link_i), .cmd_vld(cmd_vld),
        .cmd_code(cmd_code), .cmd_state(cmd_state), .cmd_rdy(cmd_rdy), .done(done),
        .status(status), .save_ctx(save_ctx), .restore_ctx(restore_ctx), .wake_seen(wake_seen));
    dps_link_properties u_dps_link_properties (.clk(clk), .rst_b(rst_b),
        .req_vld(link_i.req_vld), .req_code(link_i.req_code), .req_state(link_i.req_state),
        .rsp_vld(link_i.rsp_vld), .rsp_stat(link_i.rsp_stat), .desc(link_i.desc),
        .resume(link_i.resume));

    // clock, and pulse counters so one-cycle outputs are never missed
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (save_ctx === 1'b1) n_save++;
        if (restore_ctx === 1'b1) n_rest++;
        if (init_pls === 1'b1) n_init++;
        if (wake_seen === 1'b1 && wake_q !== 1'b1) n_wake++;
        wake_q = wake_seen;
    end

    // ----
    // shared tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one command through the host end; bounded wait for done
    task automatic issue(input dps_pkg::dps_req_e c, input dps_pkg::dps_pwr_e s);
        @(negedge clk);
        cmd_vld = 1'b1;
        cmd_code = c;
        cmd_state = s;
        @(negedge clk);
        cmd_vld = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++)
            @(posedge clk) #1;
        if (done !== 1'b1)
        begin
            failures++;
            wrap_up();
        end
    endtask
    // poll status until idle within lim cycles, then compare the state
    task automatic poll(input dps_pkg::dps_pwr_e s, input int lim);
        int t0;
        t0 = cyc;
        do
            issue(dps_pkg::DPS_REQ_GET_STATUS, s);
        while (status[3] === 1'b1 && cyc - t0 < lim);
        check(status[1:0], s);
    endtask
    task automatic go(input dps_pkg::dps_pwr_e s, input int lim);
        issue(dps_pkg::DPS_REQ_SET_STATE, s);
        poll(s, lim);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_basic;
        issue(dps_pkg::DPS_REQ_GET_STATUS, dps_pkg::DPS_ON);
        check(status[1:0], dps_pkg::DPS_ON);
        check(status[5:4], 2'h3);
        check({init_pls, func_en}, 2'h1);
        check(link_i.desc[31:16], 16'h01F4);
        check(cmd_rdy, 1'b1);
    endtask
    // k is the wait counter inside issue, so the save count is kept locally
    task automatic t_light;
        int s0;
        s0 = n_save;
        go(dps_pkg::DPS_LIGHT, 60);
        check({ctx_keep, func_en}, 2'h2);
        check(n_save, s0);
        check(ctx_lost, 1'b0);
        go(dps_pkg::DPS_ON, 60);
    endtask
    task automatic t_deep;
        int s0, r0;
        s0 = n_save;
        r0 = n_rest;
        go(dps_pkg::DPS_DEEP, 60);
        check(n_save - s0, 1);
        check(ctx_lost, 1'b1);
        go(dps_pkg::DPS_ON, 60);
        check(n_rest - r0, 1);
    endtask
    // second set while busy is answered but must not take effect
    task automatic t_off;
        int i0;
        issue(dps_pkg::DPS_REQ_SET_STATE, dps_pkg::DPS_OFF);
        issue(dps_pkg::DPS_REQ_SET_STATE, dps_pkg::DPS_LIGHT);
        poll(dps_pkg::DPS_OFF, 60);
        check(func_en, 1'b0);
        i0 = n_init;
        go(dps_pkg::DPS_ON, 120);
        check({func_en, 8'(n_init - i0)}, 9'h101);
    endtask
    task automatic t_wake;
        int w0;
        go(dps_pkg::DPS_LIGHT, 60);
        w0 = n_wake;
        for (int e = 0; e < 2; e++)
        begin
            @(negedge clk) wake_evt = 1'b1;
            @(negedge clk) wake_evt = 1'b0;
            repeat (20) @(negedge clk);
            check(n_wake - w0, e);
            issue(dps_pkg::DPS_REQ_SET_WAKE, dps_pkg::DPS_ON);
            issue(dps_pkg::DPS_REQ_GET_STATUS, dps_pkg::DPS_ON);
            check(status[2], 1'b1);
        end
        issue(dps_pkg::DPS_REQ_CLR_WAKE, dps_pkg::DPS_ON);
        go(dps_pkg::DPS_ON, 60);
    endtask
    task automatic t_reset;
        go(dps_pkg::DPS_LIGHT, 60);
        @(negedge clk);
        rst_b = 1'b0;
        @(negedge clk);
        check(init_pls, 1'b1);
        rst_b = 1'b1;
        issue(dps_pkg::DPS_REQ_GET_STATUS, dps_pkg::DPS_ON);
        check({ctx_keep, status[1:0]}, 3'h0);
    endtask

    // main sequence
    initial
    begin
        {rst_b, cmd_vld, wake_evt, wake_q, failures, n_tests, cyc} = '0;
        {n_save, n_rest, n_init, n_wake} = '0;
        ce = 1'b1;
        cmd_code = dps_pkg::DPS_REQ_GET_STATUS;
        cmd_state = dps_pkg::DPS_ON;
        repeat (20) @(negedge clk);
        check(init_pls, 1'b1);
        rst_b = 1'b1;
        t_basic();
        t_light();
        t_deep();
        t_off();
        t_wake();
        t_reset();
        wrap_up();
    end
endmodule
